// [inc/tmr_pkg.sv]
// Purpose: shared constants and types for the timer control block
// Assumes: byte-wide special-function register port, one core clock
// Notes: addresses are the register port's byte addresses

package tmr_pkg;

  // register port addresses
  localparam logic [7:0] ADDR_CTRL = 8'h91;
  localparam logic [7:0] ADDR_RL_LO = 8'h92;
  localparam logic [7:0] ADDR_RL_HI = 8'h93;
  localparam logic [7:0] ADDR_CNT_LO = 8'h94;
  localparam logic [7:0] ADDR_CNT_HI = 8'h95;

  // reset values and unmapped answer
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] RL_RESET = 16'h0000;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // field positions of timer_control
  localparam int HOF_BIT = 7;
  localparam int LOF_BIT = 6;
  localparam int LO_IRQ_EN_BIT = 5;
  localparam int CAP_EN_BIT = 4;
  localparam int SPLIT_BIT = 3;
  localparam int RUN_BIT = 2;

  // alternate clock select codes
  localparam logic [1:0] ALT_DIV12 = 2'h0;
  localparam logic [1:0] ALT_EXT8 = 2'h1;
  localparam logic [1:0] ALT_DIV12_B = 2'h2;
  localparam logic [1:0] ALT_CMP = 2'h3;

  // prescaler ratios and counter limits
  localparam int CORE_DIV = 12;
  localparam int EXT_DIV = 8;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;

  // timer_control layout, bit 7 first
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_overflow_irq_enable;
    logic capture_mode_enable;
    logic split_mode_select;
    logic run_control;
    logic [1:0] alt_clock_select;
  } tmr_ctrl_t;

  // one register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmr_sfr_req_t;

endpackage

// [verilog/tmr_sync_edge.sv]
// Purpose: bring an asynchronous level into the core clock domain
// Assumes: input may change at any time
// Notes: rise is a one-cycle registered pulse per rising edge

`timescale 1ns/1ns
`default_nettype none

module tmr_sync_edge (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // raw level
  input wire logic async_in,
  // synchronised rising edge
  output logic rise
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // two-stage synchroniser; meta_q feeds sync_q only
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  // edge detect works on the settled stage
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_q <= 1'b0;
      rise <= 1'b0;
    end else begin
      prev_q <= sync_q;
      rise <= sync_q & ~prev_q;
    end
  end

endmodule

`default_nettype wire

// [verilog/tmr_prescale.sv]
// Purpose: divide a stream of enable pulses by a fixed ratio
// Assumes: tick_in is synchronous to clk
// Notes: tick_out is a registered one-cycle pulse

`timescale 1ns/1ns
`default_nettype none

module tmr_prescale #(
  parameter int DIV = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // pulses to divide
  input wire logic tick_in,
  // one pulse per DIV input pulses
  output logic tick_out
);

  localparam int CW = (DIV < 2) ? 1 : $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  // a ratio below two cannot be divided
  if (DIV < 2) begin : g_bad_div
    $error("tmr_prescale: DIV must be at least 2");
  end

  logic [CW-1:0] cnt_q;

  // count input pulses, wrap on the last one
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && (cnt_q == LAST);
      if (tick_in) begin
        cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [verilog/tmr_timer_ctrl.sv]
// Purpose: control, status and counting logic of a 16-bit reload timer
// Assumes: register port and all strobes synchronous to clk
// Notes: comparator and oscillator inputs are raw and get synchronised

`timescale 1ns/1ns
`default_nettype none

module tmr_timer_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire tmr_pkg::tmr_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // clock control bits from the system
  input wire logic high_byte_fast_clock,
  input wire logic low_byte_fast_clock,
  // timer interrupt enable from the interrupt controller
  input wire logic timer_irq_enable,
  // raw alternate sources
  input wire logic comparator_out,
  input wire logic ext_osc,
  // interrupt request and counter view
  output logic timer_irq,
  output logic [15:0] count_value
);

  tmr_pkg::tmr_ctrl_t ctl_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] rl_q;
  logic cmp_rise;
  logic osc_rise;
  logic osc8_tick;
  logic div12_tick;
  logic alt_tick;
  logic cap_trig;
  logic lo_tick;
  logic hi_tick;
  logic lo_inc;
  logic hi_inc;
  logic lo_wrap;
  logic hi_wrap;
  logic cap_evt;
  logic ctl_wr;

  // address match of a write, used for every register
  function automatic logic wr_hit(input tmr_pkg::tmr_sfr_req_t r,
                                  input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  assign ctl_wr = wr_hit(sfr_req, tmr_pkg::ADDR_CTRL);

  // synchronise comparator and oscillator before any use
  tmr_sync_edge u_cmp_sync (
    .clk(clk),
    .srst(srst),
    .async_in(comparator_out),
    .rise(cmp_rise)
  );

  tmr_sync_edge u_osc_sync (
    .clk(clk),
    .srst(srst),
    .async_in(ext_osc),
    .rise(osc_rise)
  );

  // oscillator divided by eight, counted in synchronised edges
  tmr_prescale #(
    .DIV(tmr_pkg::EXT_DIV)
  ) u_osc_div (
    .clk(clk),
    .srst(srst),
    .tick_in(osc_rise),
    .tick_out(osc8_tick)
  );

  // core clock divided by twelve
  tmr_prescale #(
    .DIV(tmr_pkg::CORE_DIV)
  ) u_core_div (
    .clk(clk),
    .srst(srst),
    .tick_in(1'b1),
    .tick_out(div12_tick)
  );

  // alternate clock and capture trigger from one select field
  always_comb begin
    case (ctl_q.alt_clock_select)
      tmr_pkg::ALT_EXT8: begin
        alt_tick = osc8_tick;
        cap_trig = osc8_tick;
      end
      tmr_pkg::ALT_CMP: begin
        alt_tick = cmp_rise;
        cap_trig = osc8_tick;
      end
      default: begin
        alt_tick = div12_tick;
        cap_trig = cmp_rise;
      end
    endcase
  end

  // per-byte choice of core clock or the shared alternate clock
  assign lo_tick = low_byte_fast_clock ? 1'b1 : alt_tick;
  assign hi_tick = high_byte_fast_clock ? 1'b1 : alt_tick;

  // low byte free-runs in split mode, 16-bit needs run
  assign lo_inc = ctl_q.split_mode_select ? lo_tick
                : (ctl_q.run_control && lo_tick);
  // high byte needs run in split mode; it is part of the word otherwise
  assign hi_inc = ctl_q.split_mode_select
                && ctl_q.run_control && hi_tick;

  // capture needs the full 16-bit word, so split mode suppresses it
  assign cap_evt = ctl_q.capture_mode_enable
                && !ctl_q.split_mode_select && cap_trig;

  // counter next value; software byte writes override counting
  always_comb begin
    cnt_d = cnt_q;
    lo_wrap = 1'b0;
    hi_wrap = 1'b0;
    if (ctl_q.split_mode_select) begin
      if (lo_inc) begin
        if (cnt_q[7:0] == tmr_pkg::BYTE_MAX) begin
          cnt_d[7:0] = rl_q[7:0];
          lo_wrap = 1'b1;
        end else begin
          cnt_d[7:0] = cnt_q[7:0] + 8'h01;
        end
      end
      if (hi_inc) begin
        if (cnt_q[15:8] == tmr_pkg::BYTE_MAX) begin
          cnt_d[15:8] = rl_q[15:8];
          hi_wrap = 1'b1;
        end else begin
          cnt_d[15:8] = cnt_q[15:8] + 8'h01;
        end
      end
    end else if (lo_inc) begin
      lo_wrap = (cnt_q[7:0] == tmr_pkg::BYTE_MAX);
      hi_wrap = (cnt_q == tmr_pkg::WORD_MAX);
      cnt_d = hi_wrap ? rl_q : cnt_q + 16'h0001;
    end
    if (wr_hit(sfr_req, tmr_pkg::ADDR_CNT_LO)) begin
      cnt_d[7:0] = sfr_req.wdata;
    end
    if (wr_hit(sfr_req, tmr_pkg::ADDR_CNT_HI)) begin
      cnt_d[15:8] = sfr_req.wdata;
    end
  end

  // counter register
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= tmr_pkg::CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // reload register; a capture beats a software write in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      rl_q <= tmr_pkg::RL_RESET;
    end else begin
      if (wr_hit(sfr_req, tmr_pkg::ADDR_RL_LO)) begin
        rl_q[7:0] <= sfr_req.wdata;
      end
      if (wr_hit(sfr_req, tmr_pkg::ADDR_RL_HI)) begin
        rl_q[15:8] <= sfr_req.wdata;
      end
      if (cap_evt) begin
        rl_q <= cnt_q;
      end
    end
  end

  // control register; hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_q <= tmr_pkg::tmr_ctrl_t'(tmr_pkg::CTRL_RESET);
    end else begin
      if (ctl_wr) begin
        ctl_q <= tmr_pkg::tmr_ctrl_t'(sfr_req.wdata);
      end
      if (hi_wrap || cap_evt) begin
        ctl_q.high_overflow_flag <= 1'b1;
      end
      if (lo_wrap) begin
        ctl_q.low_overflow_flag <= 1'b1;
      end
    end
  end

  // read data, registered one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      sfr_rdata <= tmr_pkg::RDATA_UNMAPPED;
    end else if (sfr_req.rd) begin
      if (sfr_req.addr == tmr_pkg::ADDR_CTRL) begin
        sfr_rdata <= ctl_q;
      end else if (sfr_req.addr == tmr_pkg::ADDR_RL_LO) begin
        sfr_rdata <= rl_q[7:0];
      end else if (sfr_req.addr == tmr_pkg::ADDR_RL_HI) begin
        sfr_rdata <= rl_q[15:8];
      end else if (sfr_req.addr == tmr_pkg::ADDR_CNT_LO) begin
        sfr_rdata <= cnt_q[7:0];
      end else if (sfr_req.addr == tmr_pkg::ADDR_CNT_HI) begin
        sfr_rdata <= cnt_q[15:8];
      end else begin
        sfr_rdata <= tmr_pkg::RDATA_UNMAPPED;
      end
    end
  end

  // level request; stays while an enabled flag is set, so none is missed
  assign timer_irq = timer_irq_enable && (ctl_q.high_overflow_flag
                   || (ctl_q.low_overflow_irq_enable
                   && ctl_q.low_overflow_flag));

  assign count_value = cnt_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic cnt_wr;
  logic rl_wr;
  assign cnt_wr = wr_hit(sfr_req, tmr_pkg::ADDR_CNT_LO)
               || wr_hit(sfr_req, tmr_pkg::ADDR_CNT_HI);
  assign rl_wr = wr_hit(sfr_req, tmr_pkg::ADDR_RL_LO)
              || wr_hit(sfr_req, tmr_pkg::ADDR_RL_HI);

  sequence s_word_wrap;
    !ctl_q.split_mode_select && ctl_q.run_control && lo_tick
      && cnt_q == 16'hFFFF && !cnt_wr && !ctl_wr;
  endsequence

  sequence s_low_wrap;
    lo_inc && cnt_q[7:0] == 8'hFF && !ctl_wr;
  endsequence

  sequence s_capture;
    ctl_q.capture_mode_enable && !ctl_q.split_mode_select
      && cap_trig && !ctl_wr;
  endsequence

  a_word_wrap_reload: assert property (
    s_word_wrap |=> ctl_q.high_overflow_flag
      && cnt_q == $past(rl_q))
    else $error("16-bit wrap did not reload and set high flag");

  a_low_wrap_flag: assert property (
    s_low_wrap |=> ctl_q.low_overflow_flag)
    else $error("low byte wrap did not set low flag");

  a_flag_no_hw_clear: assert property (
    ctl_q.high_overflow_flag && !ctl_wr |=> ctl_q.high_overflow_flag)
    else $error("high flag cleared without a write");

  a_irq_high_flag: assert property (
    timer_irq_enable && ctl_q.high_overflow_flag |-> timer_irq)
    else $error("high flag set but no interrupt");

  a_irq_low_gate: assert property (
    !ctl_q.high_overflow_flag && ctl_q.low_overflow_flag |->
      timer_irq == (timer_irq_enable && ctl_q.low_overflow_irq_enable))
    else $error("low flag interrupt gating wrong");

  a_run_halts_word: assert property (
    !ctl_q.split_mode_select && !ctl_q.run_control && !cnt_wr
      |=> $stable(cnt_q))
    else $error("16-bit counter moved while halted");

  a_split_low_free: assert property (
    ctl_q.split_mode_select && lo_tick && !cnt_wr
      && cnt_q[7:0] != 8'hFF && !ctl_wr
      |=> cnt_q[7:0] == $past(cnt_q[7:0]) + 8'h01)
    else $error("split low byte did not count");

  a_split_high_reload: assert property (
    ctl_q.split_mode_select && ctl_q.run_control && hi_tick
      && cnt_q[15:8] == 8'hFF && !cnt_wr
      |=> cnt_q[15:8] == $past(rl_q[15:8]))
    else $error("split high byte did not reload");

  a_capture_copy: assert property (
    s_capture |=> rl_q == $past(cnt_q) && ctl_q.high_overflow_flag)
    else $error("capture did not copy count");

  a_core_div_gap: assert property (
    div12_tick |=> !div12_tick [*8])
    else $error("core divider ticked too soon");

  // split mode, the oscillator divider and the register port
  a_split_high_flag: assert property (
    ctl_q.split_mode_select && hi_inc && cnt_q[15:8] == 8'hFF
      |=> ctl_q.high_overflow_flag)
    else $error("high byte wrap did not set high flag");

  a_split_run_gate: assert property (
    ctl_q.split_mode_select && !ctl_q.run_control && !cnt_wr
      |=> cnt_q[15:8] == $past(cnt_q[15:8]))
    else $error("split high byte moved while halted");

  // capture would tear the byte counters apart, so split blocks it
  a_split_no_capture: assert property (
    ctl_q.split_mode_select && !rl_wr |=> $stable(rl_q))
    else $error("reload changed in split mode");

  // oscillator edges are at least two cycles apart, so ticks are sparse
  a_osc_div_gap: assert property (
    osc8_tick |=> !osc8_tick [*8])
    else $error("oscillator divider ticked too soon");

  a_cnt_byte_write: assert property (
    wr_hit(sfr_req, tmr_pkg::ADDR_CNT_LO)
      |=> cnt_q[7:0] == $past(sfr_req.wdata))
    else $error("low count byte write was lost");

  a_rdata_hold: assert property (
    !sfr_req.rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");

endmodule

`default_nettype wire

// [verification/tmr_timer_ctrl_tb.sv]
// Purpose: self-checking bench for the timer control block
// Assumes: one register request per strobe, read data one cycle later
// Notes: comparator and oscillator run free from bench logic, so the
//        alternate clocks always have activity to count

`timescale 1ns/1ns
`default_nettype none

module testbench;
  localparam logic [7:0] A_CTL = tmr_pkg::ADDR_CTRL;
  localparam logic [7:0] A_RLL = tmr_pkg::ADDR_RL_LO;
  localparam logic [7:0] A_RLH = tmr_pkg::ADDR_RL_HI;
  localparam logic [7:0] A_CNL = tmr_pkg::ADDR_CNT_LO;
  localparam logic [7:0] A_CNH = tmr_pkg::ADDR_CNT_HI;

  logic clk = 1'b0;
  logic srst = 1'b1;
  tmr_pkg::tmr_sfr_req_t req = '0;
  logic [7:0] rdata;
  logic hi_fast = 1'b0;
  logic lo_fast = 1'b0;
  logic irq_en = 1'b0;
  logic cmp_in = 1'b0;
  logic osc_in = 1'b0;
  logic irq;
  logic [15:0] cnt;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int src_cnt = 0;
  int t0;
  logic [15:0] r1;
  logic [15:0] r2;
  logic [7:0] irq_ctl [5] = '{8'h40, 8'h60, 8'h80, 8'h00, 8'hE0};
  logic irq_exp [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  int gap_exp [4] = '{12, 16, 12, 10};
  int cap_exp [4] = '{10, 16, 10, 16};

  tmr_timer_ctrl u_dut (
    .clk(clk),
    .srst(srst),
    .sfr_req(req),
    .sfr_rdata(rdata),
    .high_byte_fast_clock(hi_fast),
    .low_byte_fast_clock(lo_fast),
    .timer_irq_enable(irq_en),
    .comparator_out(cmp_in),
    .ext_osc(osc_in),
    .timer_irq(irq),
    .count_value(cnt)
  );

  // 100 MHz core clock
  always #5 clk = ~clk;

  // comparator rises every 10 cycles, oscillator every 2 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    src_cnt <= (src_cnt == 9) ? 0 : src_cnt + 1;
    cmp_in <= (src_cnt < 5);
    osc_in <= ~osc_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write strobe lasts one cycle, then one idle edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(16'(v), 16'(exp));
  endtask

  // bounded wait for a masked count value
  task automatic wait_cnt(input logic [15:0] m, input logic [15:0] v);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if ((cnt & m) === v) break;
    end
    chk(cnt & m, v);
  endtask

  task automatic next_step();
    logic [15:0] c0;
    // let the edge that returned us settle before taking the start value
    #1;
    c0 = cnt;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      #1;
      if (cnt !== c0) break;
    end
  endtask

  task automatic wait_irq();
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      #1;
      if (irq === 1'b1) break;
    end
    chk(16'(irq), 16'h0001);
  endtask

  task automatic rd_reload(output logic [15:0] v);
    rd(A_RLL, v[7:0]);
    rd(A_RLH, v[15:8]);
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    #200000;
    err_total++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // reset values, plus a write to an unmapped place that must vanish
    wr(8'h90, 8'hFF);
    for (int a = 8'h90; a <= 8'h95; a++) begin
      chk_rd(8'(a), 8'h00);
    end
    $display("test reset done");
    // flags are plain storage; interrupt follows flags and enables
    wr(A_CTL, 8'hE3);
    chk_rd(A_CTL, 8'hE3);
    for (int k = 0; k < 5; k++) begin
      irq_en <= (k != 4);
      wr(A_CTL, irq_ctl[k]);
      #1 chk(16'(irq), 16'(irq_exp[k]));
    end
    $display("test irq done");
    // 16-bit wrap from FFFF reloads and sets both flags
    irq_en <= 1'b1;
    lo_fast <= 1'b1;
    wr(A_RLL, 8'h34);
    wr(A_RLH, 8'h12);
    wr(A_CNL, 8'hFE);
    wr(A_CNH, 8'hFF);
    wr(A_CTL, 8'h04);
    wait_cnt(16'hFFFF, 16'h1234);
    chk(16'(irq), 16'h0001);
    chk_rd(A_CTL, 8'hC4);
    repeat (40) @(posedge clk);
    chk_rd(A_CTL, 8'hC4);
    wr(A_CTL, 8'h00);
    #1 r1 = cnt;
    repeat (20) @(posedge clk);
    #1 chk(cnt, r1);
    chk_rd(A_CTL, 8'h00);
    $display("test wrap done");
    // split: low byte runs without run control, high byte waits for it
    hi_fast <= 1'b1;
    wr(A_RLL, 8'h80);
    wr(A_RLH, 8'h40);
    wr(A_CNL, 8'hF0);
    wr(A_CNH, 8'hFE);
    wr(A_CTL, 8'h08);
    wait_cnt(16'h00FF, 16'h0080);
    chk(16'(cnt[15:8]), 16'h00FE);
    chk_rd(A_CTL, 8'h48);
    wr(A_CTL, 8'h4C);
    wait_cnt(16'hFF00, 16'h4000);
    chk_rd(A_CTL, 8'hCC);
    $display("test split done");
    // alternate clock per select code, interval between increments
    hi_fast <= 1'b0;
    lo_fast <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(A_CTL, 8'h04 | 8'(k));
      next_step();
      t0 = cyc;
      next_step();
      chk(16'(cyc - t0), 16'(gap_exp[k]));
    end
    $display("test altclk done");
    // capture per select code while counting every core clock
    lo_fast <= 1'b1;
    wr(A_CTL, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(A_CTL, 8'h14 | 8'(k));
      wait_irq();
      rd_reload(r1);
      wr(A_CTL, 8'h14 | 8'(k));
      wait_irq();
      rd_reload(r2);
      chk(r2 - r1, 16'(cap_exp[k]));
    end
    $display("test capture done");
    finish_test();
  end
endmodule

`default_nettype wire
